/* File: inc/eep_defs.svh */
// offsets, field positions, reset values and timing counts of the exposure-end pulse block
`ifndef EEP_DEFS_SVH
`define EEP_DEFS_SVH
// register byte offsets
`define EEP_LINE_BASE     6'h00
`define EEP_STATUS_OFS    6'h20
// line register field positions
`define EEP_DLY_LSB       0
`define EEP_WID_LSB       8
`define EEP_NEG_BIT       24
`define EEP_SEL_BIT       25
`define EEP_NOCAM_BIT     26
// status field positions
`define EEP_BUSY_LSB      0
`define EEP_LOST_LSB      8
// limits in 10 us steps
`define EEP_DLY_MAX       7'd100
`define EEP_WID_MIN       10'd4
`define EEP_WID_MAX       10'd1000
`define EEP_WID_RST       10'd500
`define EEP_DLY_RST       7'd0
// timing
`define EEP_CLK_NS        20
`define EEP_STEP_NS       10000
`define EEP_TICK_CYC      (`EEP_STEP_NS / `EEP_CLK_NS)
`endif

/* File: inc/eep_pkg.sv */
// types shared by the exposure-end pulse block
package eep_pkg;
  // per-line timing and option settings
  typedef struct packed {
    logic       nocam;  // drive strobe even with no camera
    logic       sel;    // 1: exposure-end pulse kind
    logic       neg;    // negative polarity
    logic [9:0] width;  // pulse width, 10 us steps
    logic [6:0] delay;  // delay, 10 us steps
  } eep_line_cfg_t;
  // per-line pulse sequencer states
  typedef enum logic [2:0] {
    EEP_IDLE  = 3'b001,
    EEP_DELAY = 3'b010,
    EEP_PULSE = 3'b100
  } eep_state_t;
endpackage

/* File: rtl/eep_top.sv */
// exposure-end pulse and strobe trigger output generator with wishbone registers
`timescale 1ns/10ps
`include "eep_defs.svh"
module eep_top #(
  parameter int NUM_LINES = 8,  // measurement lines
  parameter int NUM_CONN  = 8   // camera connectors fitted
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // classic wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [5:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // camera side
  input  wire logic [NUM_LINES-1:0] exposure_done_i,
  input  wire logic [NUM_LINES-1:0] strobe_req_i,
  input  wire logic [NUM_LINES-1:0] cam_present_i,
  input  wire logic                 multi_line_i,
  // output pins
  output logic [NUM_LINES-1:0]      exposure_end_pulse_o,
  output logic [NUM_LINES-1:0]      strobe_trigger_out_o
);
  import eep_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************

  // byte lane mask from wishbone select
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // merge written lanes into old word
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  sel);
    merge = (old_w & ~lane_mask(sel)) | (new_w & lane_mask(sel));
  endfunction

  // pack a line setting into its register image
  function automatic logic [31:0] cfg_word(input eep_line_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`EEP_DLY_LSB +: 7]  = c.delay;
    w[`EEP_WID_LSB +: 10] = c.width;
    w[`EEP_NEG_BIT]       = c.neg;
    w[`EEP_SEL_BIT]       = c.sel;
    w[`EEP_NOCAM_BIT]     = c.nocam;
    cfg_word = w;
  endfunction

  // unpack a write, clamping timing into the legal ranges
  function automatic eep_line_cfg_t cfg_from(input logic [31:0] w);
    eep_line_cfg_t c;
    c.delay = w[`EEP_DLY_LSB +: 7];
    c.width = w[`EEP_WID_LSB +: 10];
    c.neg   = w[`EEP_NEG_BIT];
    c.sel   = w[`EEP_SEL_BIT];
    c.nocam = w[`EEP_NOCAM_BIT];
    if (c.delay > `EEP_DLY_MAX) begin
      c.delay = `EEP_DLY_MAX;
    end
    if (c.width < `EEP_WID_MIN) begin
      c.width = `EEP_WID_MIN;
    end else if (c.width > `EEP_WID_MAX) begin
      c.width = `EEP_WID_MAX;
    end
    cfg_from = c;
  endfunction

  // ************************************************************
  // bus decode
  // ************************************************************

  localparam int          TICK_CYC = `EEP_TICK_CYC;  // clocks per 10 us
  localparam logic [8:0]  TICK_TOP = 9'(TICK_CYC - 1);

  eep_line_cfg_t          cfg_q [NUM_LINES];  // per-line settings
  eep_state_t             st_q  [NUM_LINES];  // sequencer state
  logic [9:0]             cnt_q [NUM_LINES];  // tick down-counter
  logic [NUM_LINES-1:0]   lost_q;             // event hit a busy line
  logic [NUM_LINES-1:0]   busy;               // line not idle
  logic [8:0]             tick_cnt_q;         // divider for the tick
  logic                   tick;               // one-cycle 10 us enable
  logic                   ack_q;              // registered ack
  logic [31:0]            rdat_q;             // registered read data
  logic                   req;                // new bus request
  logic                   wr;                 // write strobe
  logic                   stat_hit;           // status selected
  logic                   line_hit;           // a line register selected
  logic [2:0]             line_idx;           // selected line
  logic                   sel_exp;            // exposure-end kind active

  // a request is taken once; ack drops the cycle after
  assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr       = req & wb_we_i;
  assign line_idx = wb_adr_i[4:2];

  // address decode, unmapped reads zero and writes vanish
  always_comb begin
    stat_hit = 1'b0;
    line_hit = 1'b0;
    if (wb_adr_i == `EEP_STATUS_OFS) begin
      stat_hit = 1'b1;
    end else if (wb_adr_i[5] == 1'b0 && wb_adr_i[1:0] == 2'b00 && 32'(line_idx) < NUM_LINES) begin
      line_hit = 1'b1;
    end
  end

  // ack and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req) begin
        if (stat_hit) begin
          rdat_q <= 32'({lost_q, busy}) & 32'h0000_FFFF;
        end else if (line_hit) begin
          rdat_q <= cfg_word(cfg_q[line_idx]);
        end else begin
          rdat_q <= 32'h0000_0000;
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ************************************************************
  // settings
  // ************************************************************

  // line settings, factory defaults after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int n = 0; n < NUM_LINES; n++) begin
        cfg_q[n].delay <= `EEP_DLY_RST;
        cfg_q[n].width <= `EEP_WID_RST;
        cfg_q[n].neg   <= 1'b0;
        cfg_q[n].sel   <= 1'b0;
        cfg_q[n].nocam <= 1'b0;
      end
    end else if (wr && line_hit) begin
      cfg_q[line_idx] <= cfg_from(merge(cfg_word(cfg_q[line_idx]), wb_dat_i, wb_sel_i));
    end
  end

  // kind is common; only the sel bit of line 0 counts, every line obeys it
  assign sel_exp = cfg_q[0].sel;

  // ************************************************************
  // 10 us tick
  // ************************************************************

  // free-running divider; first step after an event may be short
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= 9'h000;
    end else if (tick_cnt_q == TICK_TOP) begin
      tick_cnt_q <= 9'h000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 9'h001;
    end
  end

  assign tick = (tick_cnt_q == TICK_TOP);

  // ************************************************************
  // per-line pulse sequencers
  // ************************************************************

  // every exposure-done pulse is one image: multi-exposure and live alike
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int n = 0; n < NUM_LINES; n++) begin
        st_q[n]  <= EEP_IDLE;
        cnt_q[n] <= 10'h000;
      end
    end else begin
      for (int n = 0; n < NUM_LINES; n++) begin
        if (!sel_exp) begin
          // strobe kind: pulse side stays quiet
          st_q[n]  <= EEP_IDLE;
          cnt_q[n] <= 10'h000;
        end else if (exposure_done_i[n]) begin
          // reload on each event, even mid-pulse
          if (cfg_q[n].delay == 7'd0) begin
            st_q[n]  <= EEP_PULSE;
            cnt_q[n] <= cfg_q[n].width - 10'd1;
          end else begin
            st_q[n]  <= EEP_DELAY;
            cnt_q[n] <= {3'b000, cfg_q[n].delay} - 10'd1;
          end
        end else if (tick) begin
          case (st_q[n])
            EEP_DELAY: begin
              if (cnt_q[n] == 10'h000) begin
                st_q[n]  <= EEP_PULSE;
                cnt_q[n] <= cfg_q[n].width - 10'd1;
              end else begin
                cnt_q[n] <= cnt_q[n] - 10'd1;
              end
            end
            EEP_PULSE: begin
              if (cnt_q[n] == 10'h000) begin
                st_q[n] <= EEP_IDLE;
              end else begin
                cnt_q[n] <= cnt_q[n] - 10'd1;
              end
            end
            default: begin
              st_q[n] <= EEP_IDLE;
            end
          endcase
        end
      end
    end
  end

  // busy view for status
  always_comb begin
    for (int n = 0; n < NUM_LINES; n++) begin
      busy[n] = (st_q[n] != EEP_IDLE);
    end
  end

  // an event on a busy line restarts its sequence; sticky, set beats clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lost_q <= '0;
    end else begin
      for (int n = 0; n < NUM_LINES; n++) begin
        if (sel_exp && exposure_done_i[n] && busy[n]) begin
          lost_q[n] <= 1'b1;
        end else if (wr && stat_hit && wb_sel_i[1] && wb_dat_i[`EEP_LOST_LSB + n]) begin
          lost_q[n] <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // output pins
  // ************************************************************

  // pulse pin n is line n; idle level set by polarity
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      exposure_end_pulse_o <= '0;
    end else begin
      for (int n = 0; n < NUM_LINES; n++) begin
        exposure_end_pulse_o[n] <= (st_q[n] == EEP_PULSE) ^ cfg_q[n].neg;
      end
    end
  end

  // strobe pin n is connector n, only fitted connectors may drive
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_trigger_out_o <= '0;
    end else begin
      for (int n = 0; n < NUM_LINES; n++) begin
        strobe_trigger_out_o[n] <= !sel_exp && strobe_req_i[n] && (n < NUM_CONN)
                                   && (cam_present_i[n] || cfg_q[n].nocam);
      end
    end
  end

endmodule

/* File: dv/eep_watch.sv */
// pin watcher standing in for a strobe or controller input
`timescale 1ns/10ps
module eep_watch (
  input  wire logic clk_i,
  input  wire logic act_i, // level read as on
  input  wire logic pin_i, // watched pin
  output int        len_o, // cycles of last pulse
  output int        cnt_o  // pulses seen
);
  int run_q; // on cycles so far
  // a pulse counts once it has ended, so a cut-short one still shows
  always_ff @(posedge clk_i) begin
    if (pin_i == act_i) begin
      run_q <= run_q + 1;
    end else if (run_q != 0) begin
      len_o <= run_q;
      cnt_o <= cnt_o + 1;
      run_q <= 0;
    end
  end
endmodule

/* File: dv/eep_checker.sv */
// port assertions of the exposure-end pulse block
`timescale 1ns/10ps
module eep_checker #(
  parameter int NUM_LINES = 8,
  parameter int NUM_CONN  = 8
) (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire logic [NUM_LINES-1:0] strobe_req_i,
  input wire logic [NUM_LINES-1:0] exposure_end_pulse_o,
  input wire logic [NUM_LINES-1:0] strobe_trigger_out_o
);
  // ****************
  // bus and pins
  // ****************
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_on_ack: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved");
  // reset sees positive polarity, so pulse pins idle low
  a_rst_quiet: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && exposure_end_pulse_o == '0)
    else $error("pins busy after reset");
  a_strobe_cause: assert property ((strobe_trigger_out_o & ~$past(strobe_req_i)) == '0)
    else $error("strobe without request");
  a_strobe_fitted: assert property ((strobe_trigger_out_o >> NUM_CONN) == '0)
    else $error("unfitted strobe driven");
  // a write may move idle levels, so skip two cycles after it
  a_one_kind: assert property (|strobe_trigger_out_o && !$past(wb_ack_o) && !$past(wb_ack_o, 2)
    |-> $stable(exposure_end_pulse_o)) else $error("both kinds driven");
  c_strobe: cover property (|strobe_trigger_out_o);
  c_pulse: cover property ($changed(exposure_end_pulse_o));
  c_ack: cover property (wb_ack_o);
endmodule

/* File: dv/eep_top_bench.sv */
// self-checking bench of the exposure-end pulse block
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %s exp %h got %h", n, e, g); end end
module eep_top_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0; // stb rides with cyc
  logic        we    = 1'b0;
  logic        ml    = 1'b0; // multi-line mode
  logic [5:0]  adr   = 6'h00;
  logic [3:0]  be    = 4'hF; // byte lanes
  logic [31:0] wdat  = 32'h0000_0000;
  logic [7:0]  done  = 8'h00; // exposure ends
  logic [7:0]  sreq  = 8'h00; // strobe timing
  logic [7:0]  pres  = 8'h00; // cameras present
  logic [31:0] rdat;
  logic        ack;
  logic [7:0]  pulse;
  logic [7:0]  strobe;
  logic [31:0] v;   // last read
  int          c;   // wait length
  int          len;
  int          npul;
  int          error_cnt = 0;
  int          n_checks  = 0;
  int          cyc_cnt   = 0;
  // four fitted connectors to reach the unfitted case
  eep_top #(.NUM_LINES(8), .NUM_CONN(4)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(be), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .exposure_done_i(done), .strobe_req_i(sreq), .cam_present_i(pres), .multi_line_i(ml),
    .exposure_end_pulse_o(pulse), .strobe_trigger_out_o(strobe));
  eep_watch u_watch (.clk_i(clk_i), .act_i(1'b1), .pin_i(pulse[0]), .len_o(len), .cnt_o(npul));
  always #10 clk_i = ~clk_i;
  // hang guard, runs stay under 10000 cycles
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 60000) begin
      error_cnt++;
      finish_test();
    end
  end
  // ****************
  // shared tasks
  // ****************
  // classic cycle, held until ack; only the hang guard ends the wait
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    c = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      c++;
    end while (ack !== 1'b1);
    v = rdat;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic expose(input logic [7:0] m);
    done <= m;
    @(posedge clk_i);
    done <= 8'h00;
  endtask
  task automatic wait_pin(input int n, input logic lv);
    c = 0;
    while (pulse[n] !== lv && c < 3000) begin
      @(posedge clk_i);
      c++;
    end
    `CHK("pin wait", 1'b1, c < 3000)
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_defaults();
    `CHK("pins", 8'h00, pulse)
    wb(1'b0, 6'h00, 32'h0);
    `CHK("line0", 32'h0001_F400, v)
    wb(1'b0, 6'h24, 32'h0);
    `CHK("unmapped", 32'h0000_0000, v)
  endtask
  task automatic t_strobe();
    pres <= 8'h05;
    sreq <= 8'hFF;
    expose(8'hFF);
    repeat (3) @(posedge clk_i);
    `CHK("strobe", 8'h05, strobe)
    `CHK("quiet", 8'h00, pulse)
    wb(1'b1, 6'h04, 32'h0401_F400);
    wb(1'b1, 6'h18, 32'h0401_F400);
    `CHK("nocam", 8'h07, strobe)
  endtask
  task automatic t_pulse();
    ml <= 1'b1;
    wb(1'b1, 6'h00, 32'h0200_0400);
    wb(1'b1, 6'h0C, 32'h0100_0402);
    `CHK("kind", 8'h00, strobe)
    `CHK("idle", 8'h08, pulse)
    for (int i = 0; i < 2; i++) begin
      expose(8'h01);
      wait_pin(0, 1'b1);
      `CHK("dly0", 1'b1, c <= 3)
      wait_pin(0, 1'b0);
      @(posedge clk_i);
      `CHK("width", 1'b1, len >= 1500 && len <= 2001)
    end
    `CHK("count", 2, npul)
    expose(8'h08);
    wait_pin(3, 1'b0);
    `CHK("dly2", 1'b1, c >= 499 && c <= 1003)
    wait_pin(3, 1'b1);
    `CHK("width3", 1'b1, c >= 1499 && c <= 2001)
  endtask
  task automatic t_retrig();
    expose(8'h01);
    repeat (100) @(posedge clk_i);
    expose(8'h01);
    wb(1'b0, 6'h20, 32'h0);
    `CHK("lost", 32'h0000_0101, v)
    wait_pin(0, 1'b0);
    @(posedge clk_i);
    `CHK("restart", 1'b1, len >= 1550 && len <= 2150)
    // clear without lane 1 must leave the flag set
    be <= 4'hD;
    wb(1'b1, 6'h20, 32'h0000_0100);
    be <= 4'hF;
    wb(1'b0, 6'h20, 32'h0);
    `CHK("lane off", 32'h0000_0100, v)
    wb(1'b1, 6'h20, 32'h0000_0100);
    wb(1'b0, 6'h20, 32'h0);
    `CHK("cleared", 32'h0000_0000, v)
    wb(1'b1, 6'h1C, 32'h0000_017F);
    wb(1'b0, 6'h1C, 32'h0);
    `CHK("clamp", 32'h0000_0464, v)
  endtask
  // mid-run reset brings back factory settings and strobe kind
  task automatic t_reset();
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK("rst pins", 8'h00, pulse)
    wb(1'b0, 6'h0C, 32'h0);
    `CHK("rst line3", 32'h0001_F400, v)
    `CHK("rst kind", 8'h05, strobe)
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_defaults();
    t_strobe();
    t_pulse();
    t_retrig();
    t_reset();
    finish_test();
  end
endmodule
bind eep_top eep_checker #(.NUM_LINES(NUM_LINES), .NUM_CONN(NUM_CONN)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .strobe_req_i(strobe_req_i),
  .exposure_end_pulse_o(exposure_end_pulse_o), .strobe_trigger_out_o(strobe_trigger_out_o));
